// *** logic/pfc_cfg.svh ***
/*
  Offsets, field positions, reset values and fixed codes of the flash
  prefetch cache controller.
  Assumes byte addresses on an 8-bit register address port.
*/
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define PFC_OFF_CONTROL   8'h00
`define PFC_OFF_ACCESS    8'h04
`define PFC_OFF_TAG       8'h08
`define PFC_OFF_MASK      8'h0c
`define PFC_OFF_WORD0     8'h10

// ****************************************
// Field positions
// ****************************************
`define PFC_CTL_COH_BIT   16
`define PFC_CTL_DATA_LINE_COUNT_LO   8
`define PFC_CTL_PREF_LO   4
`define PFC_CTL_WS_LO     0
`define PFC_TAG_BOOT_BIT  31
`define PFC_TAG_ADDR_LO   4
`define PFC_TAG_VALID_BIT 3
`define PFC_TAG_LOCK_BIT  2
`define PFC_TAG_KIND_BIT  1
`define PFC_MASK_LO       5

// ****************************************
// Reset values and fixed codes
// ****************************************
`define PFC_RST_WS        3'h7
`define PFC_RST_DATA_LINE_COUNT      2'h0
`define PFC_RST_PREF      2'h0
`define PFC_RST_COH       1'b0
`define PFC_RST_KIND      1'b1
`define PFC_MASK_LINE_A   4'ha
`define PFC_MASK_LINE_B   4'hb
`define PFC_REGION_BOOT1  8'h1d
`define PFC_REGION_BOOT0  8'h1f

`endif

// *** logic/pfc_pkg.sv ***
/*
  Types and small decoders of the flash prefetch cache controller.
  Assumes pfc_cfg.svh is on the include path.
*/
`include "pfc_cfg.svh"

package pfc_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_FLUSH = 2'b10
  } flush_state_e;

  typedef struct packed {
    logic        boot;
    logic [19:0] tag;
    logic        valid;
    logic        lock;
    logic        kind;
    logic [31:0] word0;
  } line_s;

  // Data lines granted by the size code
  function automatic logic [2:0] data_line_count_f(input logic [1:0] code);
    unique case (code)
      2'b11:   data_line_count_f = 3'h4;
      2'b10:   data_line_count_f = 3'h2;
      2'b01:   data_line_count_f = 3'h1;
      default: data_line_count_f = 3'h0;
    endcase
  endfunction : data_line_count_f

  // Upper address byte of the region a line lives in
  function automatic logic [7:0] region_f(input logic boot);
    region_f = boot ? `PFC_REGION_BOOT1 : `PFC_REGION_BOOT0;
  endfunction : region_f

endpackage : pfc_pkg

// *** logic/pfc_tag_match.sv ***
/*
  Hit comparator for one cache line.
  Assumes a physical fetch address and the line fields held by the parent.
*/
`timescale 1ns/10ps
`default_nettype none

module pfc_tag_match
  import pfc_pkg::*;
(
  input  wire logic        i_valid,
  input  wire logic        i_boot,
  input  wire logic        i_kind,
  input  wire logic [19:0] i_tag,
  input  wire logic [10:0] i_mask,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_kind_req,
  output logic             o_match
);

  logic [19:0] diff;
  logic [19:0] care;

  // Mask bits line up with address bits 15:5, i.e. tag bits 11:1
  assign care    = ~{8'h00, i_mask, 1'b0};
  assign diff    = (i_tag ^ i_addr[23:4]) & care;
  // Invalid lines never take part
  assign o_match = i_valid && (i_kind == i_kind_req) &&
                   (region_f(i_boot) == i_addr[31:24]) && (diff == 20'h00000);

endmodule : pfc_tag_match

`default_nettype wire

// *** logic/pfc_victim_pick.sv ***
/*
  Round-robin replacement picker.
  Assumes LINES is a power of two and candidates already exclude locked lines.
*/
`timescale 1ns/10ps
`default_nettype none

module pfc_victim_pick #(
  parameter int LINES = 16,
  parameter int IW    = 4
) (
  input  wire logic [LINES-1:0] i_cand,
  input  wire logic [IW-1:0]    i_start,
  output logic                  o_found,
  output logic [IW-1:0]         o_line
);

  // First candidate at or after the start point wins
  always_comb begin
    logic [IW-1:0] idx;
    idx     = '0;
    o_found = 1'b0;
    o_line  = '0;
    for (int k = LINES - 1; k >= 0; k--) begin
      idx = i_start + IW'(k);
      if (i_cand[idx]) begin
        o_found = 1'b1;
        o_line  = idx;
      end
    end
  end

endmodule : pfc_victim_pick

`default_nettype wire

// *** logic/pfc_ctrl.sv ***
/*
  Flash prefetch cache controller: control registers, line tag store,
  hit detection, fills, replacement and invalidation.
  Assumes a single 100 MHz clock, a synchronous active-low reset and a
  register master that keeps to one-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pfc_cfg.svh"

module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int LINES = 16,
  parameter int IW    = 4
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  input  wire logic [7:0]    i_addr,
  input  wire logic [31:0]   i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [31:0]   o_rdata,
  input  wire logic          i_code_protect,
  input  wire logic          i_flash_program,
  input  wire logic          i_lookup_valid,
  input  wire logic [31:0]   i_lookup_addr,
  input  wire logic          i_lookup_kind,
  output logic               o_lookup_ready,
  output logic               o_hit,
  output logic      [IW-1:0] o_hit_line,
  output logic      [31:0]   o_hit_word,
  input  wire logic          i_fill_valid,
  input  wire logic [31:0]   i_fill_addr,
  input  wire logic [31:0]   i_fill_word,
  input  wire logic          i_fill_kind,
  output logic               o_fill_taken,
  output logic      [2:0]    o_wait_states,
  output logic               o_prefetch_cacheable,
  output logic               o_prefetch_noncacheable,
  output logic      [2:0]    o_data_lines
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    flush_state_e          state;
    logic                  flush_req;
    logic                  flush_all;
    logic                  coh;
    logic [1:0]            data_line_count;
    logic [1:0]            pref;
    logic [2:0]            ws;
    logic [IW-1:0]         index;
    logic [IW-1:0]         rr;
    line_s [LINES-1:0]     lines;
    logic [1:0][10:0]      masks;
    logic [31:0]           rdata;
    logic                  hit;
    logic [IW-1:0]         hit_line;
    logic [31:0]           hit_word;
  } ctl_s;

  ctl_s st_reg;
  ctl_s st_next;

  logic [LINES-1:0] match;
  logic [LINES-1:0] cand;
  logic [LINES-1:0] valid_vec;
  logic [LINES-1:0] data_valid_vec;
  logic             victim_found;
  logic [IW-1:0]    victim_line;
  logic [2:0]       ndata;
  logic             data_line_count_change;
  logic             mask_slot_ok;

  // ****************************************
  // Per-line comparators and candidate mask
  // ****************************************
  assign ndata = data_line_count_f(st_reg.data_line_count);

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      logic [10:0] line_mask;
      // Only two lines own a mask; all others compare every bit
      if (g == 10) begin : g_ma
        assign line_mask = st_reg.masks[0];
      end else if (g == 11) begin : g_mb
        assign line_mask = st_reg.masks[1];
      end else begin : g_mz
        assign line_mask = 11'h000;
      end
      pfc_tag_match u_match (
        .i_valid    (st_reg.lines[g].valid),
        .i_boot     (st_reg.lines[g].boot),
        .i_kind     (st_reg.lines[g].kind),
        .i_tag      (st_reg.lines[g].tag),
        .i_mask     (line_mask),
        .i_addr     (i_lookup_addr),
        .i_kind_req (i_lookup_kind),
        .o_match    (match[g])
      );
      // Data fills use the lowest lines, instruction fills the rest
      assign cand[g] = !st_reg.lines[g].lock &&
                       ((g < int'(ndata)) == !i_fill_kind);
      assign valid_vec[g]      = st_reg.lines[g].valid;
      assign data_valid_vec[g] = st_reg.lines[g].valid && !st_reg.lines[g].kind;
    end
  endgenerate

  pfc_victim_pick #(
    .LINES (LINES),
    .IW    (IW)
  ) u_pick (
    .i_cand  (cand),
    .i_start (st_reg.rr),
    .o_found (victim_found),
    .o_line  (victim_line)
  );

  // ****************************************
  // Handshakes and configuration outputs
  // ****************************************
  // Lookups wait while a flush is due, so no stale line can hit
  assign o_lookup_ready = (st_reg.state == ST_RUN) && !st_reg.flush_req &&
                          !i_flash_program;
  assign o_fill_taken   = o_lookup_ready && i_fill_valid && victim_found &&
                          !(i_fill_kind == 1'b0 && ndata == 3'h0);
  assign o_wait_states  = st_reg.ws;
  assign o_prefetch_cacheable    = st_reg.pref[0];
  assign o_prefetch_noncacheable = st_reg.pref[1];
  assign o_data_lines   = ndata;
  assign o_rdata        = st_reg.rdata;
  assign o_hit          = st_reg.hit;
  assign o_hit_line     = st_reg.hit_line;
  assign o_hit_word     = st_reg.hit_word;

  assign data_line_count_change  = i_wr && (i_addr == `PFC_OFF_CONTROL) &&
                        (i_wdata[`PFC_CTL_DATA_LINE_COUNT_LO +: 2] != st_reg.data_line_count);
  assign mask_slot_ok = (st_reg.index == IW'(`PFC_MASK_LINE_A)) ||
                        (st_reg.index == IW'(`PFC_MASK_LINE_B));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next     = st_reg;
    st_next.hit = 1'b0;

    // Flush machine: one cycle in FLUSH clears the chosen lines
    unique case (st_reg.state)
      ST_RUN: begin
        if (st_reg.flush_req) begin
          st_next.state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        for (int i = 0; i < LINES; i++) begin
          // Locked instruction lines survive unless coherency or a size change forces all
          if (st_reg.flush_all || st_reg.coh || !st_reg.lines[i].kind ||
              !st_reg.lines[i].lock) begin
            st_next.lines[i].valid = 1'b0;
          end
        end
        st_next.flush_req = 1'b0;
        st_next.flush_all = 1'b0;
        st_next.state     = ST_RUN;
      end
    endcase

    // Lookup result is registered; the match vector is one-hot in practice
    if (i_lookup_valid && o_lookup_ready) begin
      for (int i = 0; i < LINES; i++) begin
        if (match[i]) begin
          st_next.hit      = 1'b1;
          st_next.hit_line = IW'(i);
          st_next.hit_word = st_reg.lines[i].word0;
        end
      end
    end

    // Fill into the picked victim
    if (o_fill_taken) begin
      st_next.lines[victim_line].tag   = i_fill_addr[23:4];
      st_next.lines[victim_line].boot  = (i_fill_addr[31:24] == `PFC_REGION_BOOT1);
      st_next.lines[victim_line].valid = 1'b1;
      st_next.lines[victim_line].lock  = 1'b0;
      st_next.lines[victim_line].kind  = i_fill_kind;
      st_next.lines[victim_line].word0 = i_fill_word;
      st_next.rr = victim_line + IW'(1);
    end

    // Register writes; unused bits are simply dropped
    if (i_wr) begin
      unique case (i_addr)
        `PFC_OFF_CONTROL: begin
          st_next.coh  = i_wdata[`PFC_CTL_COH_BIT];
          st_next.data_line_count = i_wdata[`PFC_CTL_DATA_LINE_COUNT_LO +: 2];
          st_next.pref = i_wdata[`PFC_CTL_PREF_LO +: 2];
          st_next.ws   = i_wdata[`PFC_CTL_WS_LO +: 3];
        end
        `PFC_OFF_ACCESS: begin
          st_next.index = i_wdata[IW-1:0];
        end
        `PFC_OFF_TAG: begin
          st_next.lines[st_reg.index].boot  = i_wdata[`PFC_TAG_BOOT_BIT];
          st_next.lines[st_reg.index].tag   = i_wdata[`PFC_TAG_ADDR_LO +: 20];
          st_next.lines[st_reg.index].valid = i_wdata[`PFC_TAG_VALID_BIT];
          st_next.lines[st_reg.index].lock  = i_wdata[`PFC_TAG_LOCK_BIT];
          st_next.lines[st_reg.index].kind  = i_wdata[`PFC_TAG_KIND_BIT];
        end
        `PFC_OFF_MASK: begin
          if (mask_slot_ok) begin
            st_next.masks[st_reg.index[0]] = i_wdata[`PFC_MASK_LO +: 11];
          end
        end
        `PFC_OFF_WORD0: begin
          st_next.lines[st_reg.index].word0 = i_wdata;
        end
        default: begin
        end
      endcase
    end

    // Requests are set after the FLUSH clear, so a late pulse is kept
    if (i_flash_program) begin
      st_next.flush_req = 1'b1;
    end
    if (data_line_count_change) begin
      st_next.flush_req = 1'b1;
      st_next.flush_all = 1'b1;
    end

    // Read data stand in the cycle after the strobe only
    st_next.rdata = 32'h00000000;
    if (i_rd) begin
      unique case (i_addr)
        `PFC_OFF_CONTROL: begin
          st_next.rdata = {15'h0000, st_reg.coh, 6'h00, st_reg.data_line_count, 2'h0,
                           st_reg.pref, 1'b0, st_reg.ws};
        end
        `PFC_OFF_ACCESS: begin
          st_next.rdata = 32'(st_reg.index);
        end
        `PFC_OFF_TAG: begin
          st_next.rdata = {st_reg.lines[st_reg.index].boot, 7'h00,
                           st_reg.lines[st_reg.index].tag,
                           st_reg.lines[st_reg.index].valid,
                           st_reg.lines[st_reg.index].lock,
                           st_reg.lines[st_reg.index].kind, 1'b0};
        end
        `PFC_OFF_MASK: begin
          if (mask_slot_ok) begin
            st_next.rdata = {16'h0000, st_reg.masks[st_reg.index[0]], 5'h00};
          end
        end
        `PFC_OFF_WORD0: begin
          // Protected parts never leak cached code through this port
          if (!i_code_protect) begin
            st_next.rdata = st_reg.lines[st_reg.index].word0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st_reg       <= '0;
      st_reg.state <= ST_RUN;
      st_reg.coh   <= `PFC_RST_COH;
      st_reg.data_line_count  <= `PFC_RST_DATA_LINE_COUNT;
      st_reg.pref  <= `PFC_RST_PREF;
      st_reg.ws    <= `PFC_RST_WS;
      for (int i = 0; i < LINES; i++) begin
        st_reg.lines[i].kind <= `PFC_RST_KIND;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_WAIT_STATES: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_wr && i_addr == `PFC_OFF_CONTROL) |=> (o_wait_states == $past(i_wdata[2:0])))
    else $error("wait states not taken from control write");

  AST_DATA_SIZE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_wr && i_addr == `PFC_OFF_CONTROL && i_wdata[9:8] == 2'b11) |=> (o_data_lines == 3'h4))
    else $error("size code 11 did not give four data lines");

  AST_SIZE_FLUSH: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    data_line_count_change ##1 !i_wr ##1 (!i_wr && !o_fill_taken) |-> ##1 (valid_vec == '0))
    else $error("lines still valid after size change");

  AST_PROGRAM_DATA: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_flash_program && !i_wr) ##1 !i_wr ##1 (!i_wr && !o_fill_taken)
      |-> ##1 (data_valid_vec == '0))
    else $error("data lines valid after program cycle");

  AST_PROGRAM_STALL: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_flash_program |-> !o_lookup_ready ##1 !o_lookup_ready)
    else $error("lookup accepted during pending flush");

  AST_HIT_CAUSE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_hit |-> $past(i_lookup_valid && o_lookup_ready && match != '0))
    else $error("hit without accepted matching lookup");

  AST_MASK_GUARD: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_wr && i_addr == `PFC_OFF_MASK && !mask_slot_ok) |=> $stable(st_reg.masks))
    else $error("mask written for a line without mask logic");

  AST_PROTECT_READ: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_rd && i_addr == `PFC_OFF_WORD0 && i_code_protect) |=> (o_rdata == 32'h00000000))
    else $error("word zero readable while protected");

  AST_NO_LOCKED_VICTIM: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_fill_taken |-> !st_reg.lines[victim_line].lock)
    else $error("locked line chosen for replacement");

  AST_PREFETCH: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_wr && i_addr == `PFC_OFF_CONTROL) |=>
      ({o_prefetch_noncacheable, o_prefetch_cacheable} == $past(i_wdata[5:4])))
    else $error("prefetch enables not taken from select field");

endmodule : pfc_ctrl

`default_nettype wire

// *** test/pfc_core_model.sv ***
/*
  Core-side model: issues lookups and fills towards pfc_ctrl.
  Assumes the bench calls fetch and fill one at a time.
*/
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Fetch and fill requester
// ****************************************
module pfc_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_ready,
  input  wire logic        i_hit,
  input  wire logic [3:0]  i_hit_line,
  input  wire logic [31:0] i_hit_word,
  input  wire logic        i_fill_taken,
  output var  logic        o_lookup_valid,
  output var  logic [31:0] o_lookup_addr,
  output var  logic        o_lookup_kind,
  output var  logic        o_fill_valid,
  output var  logic [31:0] o_fill_addr,
  output var  logic [31:0] o_fill_word,
  output var  logic        o_fill_kind
);
  // Idle lines start quiet
  initial begin
    o_lookup_valid = 1'b0;
    o_lookup_addr  = 32'h0;
    o_lookup_kind  = 1'b0;
    o_fill_valid   = 1'b0;
    o_fill_addr    = 32'h0;
    o_fill_word    = 32'h0;
    o_fill_kind    = 1'b0;
  end

  // Request held until ready seen at an edge; result read next cycle
  task automatic fetch(input logic [31:0] a, input logic k, output logic h,
                       output logic [3:0] l, output logic [31:0] w);
    logic t;
    t = 1'b0;
    @(posedge i_clk);
    o_lookup_valid <= 1'b1;
    o_lookup_addr  <= a;
    o_lookup_kind  <= k;
    while (!t) begin
      @(negedge i_clk);
      t = i_ready;
      @(posedge i_clk);
    end
    o_lookup_valid <= 1'b0;
    o_lookup_addr  <= ~a; // Released bus shows no stale address
    o_lookup_kind  <= ~k;
    #1;
    h = i_hit;
    l = i_hit_line;
    w = i_hit_word;
  endtask : fetch

  // Fill held until the controller takes it
  task automatic fill(input logic [31:0] a, input logic [31:0] d, input logic k);
    logic t;
    t = 1'b0;
    @(posedge i_clk);
    o_fill_valid <= 1'b1;
    o_fill_addr  <= a;
    o_fill_word  <= d;
    o_fill_kind  <= k;
    while (!t) begin
      @(negedge i_clk);
      t = i_fill_taken;
      @(posedge i_clk);
    end
    o_fill_valid <= 1'b0;
    o_fill_addr  <= ~a;
    o_fill_word  <= ~d;
  endtask : fill
endmodule : pfc_core_model

`default_nettype wire

// *** test/testbench.sv ***
/*
  Self-checking bench of pfc_ctrl: a table of control codes, then tests
  of tags, masks, flushes and fills. Assumes pfc_core_model drives fetches.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pfc_cfg.svh"

module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk   = 1'b0;
  logic        nrst  = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd_s  = 1'b0;
  logic        prot  = 1'b0;
  logic        prog  = 1'b0;
  logic [31:0] rdata, la, fa, fw, hword, last_word;
  logic        lv, lk, fv, fk, rdy, hit, ftaken, pc, pnc;
  logic [3:0]  hline;
  logic [2:0]  ws, dl;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;
  // Control writes and {wait, pref nc, pref c, lines}; unused bits zero
  logic [31:0] row_w [8] = '{32'h0, 32'h111, 32'h222, 32'h333,
                             32'h10004, 32'h15, 32'h126, 32'h337};
  logic [7:0]  row_e [8] = '{8'h00, 8'h29, 8'h52, 8'h7c,
                             8'h80, 8'ha8, 8'hd1, 8'hfc};

  always #5 clk = ~clk;

  pfc_ctrl #(.LINES(16), .IW(4)) i_pfc_ctrl (
    .i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata), .i_code_protect(prot),
    .i_flash_program(prog), .i_lookup_valid(lv), .i_lookup_addr(la),
    .i_lookup_kind(lk), .o_lookup_ready(rdy), .o_hit(hit),
    .o_hit_line(hline), .o_hit_word(hword), .i_fill_valid(fv),
    .i_fill_addr(fa), .i_fill_word(fw), .i_fill_kind(fk),
    .o_fill_taken(ftaken), .o_wait_states(ws), .o_prefetch_cacheable(pc),
    .o_prefetch_noncacheable(pnc), .o_data_lines(dl));

  pfc_core_model i_pfc_core_model (
    .i_clk(clk), .i_ready(rdy), .i_hit(hit), .i_hit_line(hline),
    .i_hit_word(hword), .i_fill_taken(ftaken), .o_lookup_valid(lv),
    .o_lookup_addr(la), .o_lookup_kind(lk), .o_fill_valid(fv),
    .o_fill_addr(fa), .o_fill_word(fw), .o_fill_kind(fk));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle strobes launched just after an edge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rchk

  task automatic line(input logic [3:0] i, input logic [31:0] t);
    wreg(`PFC_OFF_ACCESS, {28'h0, i});
    wreg(`PFC_OFF_TAG, t);
  endtask : line

  task automatic pulse;
    @(posedge clk);
    prog <= 1'b1;
    @(posedge clk);
    prog <= 1'b0;
    #1;
    chk({31'h0, rdy}, 32'h0);
  endtask : pulse

  task automatic look(input logic [31:0] a, input logic k, input logic eh,
                      input logic [3:0] el);
    logic        h;
    logic [3:0]  l;
    logic [31:0] w;
    i_pfc_core_model.fetch(a, k, h, l, w);
    chk({31'h0, h}, {31'h0, eh});
    if (eh) begin
      chk({28'h0, l}, {28'h0, el});
    end
    last_word = w;
  endtask : look

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk({29'h0, ws}, 32'h7);
    rchk(`PFC_OFF_CONTROL, 32'h7);
    rchk(`PFC_OFF_TAG, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wreg(`PFC_OFF_CONTROL, row_w[i]);
      #1;
      chk({24'h0, ws, pnc, pc, dl}, {24'h0, row_e[i]});
      rchk(`PFC_OFF_CONTROL, row_w[i]);
    end
    // Locked instruction line 5 in the boot region
    line(4'h5, 32'h8000_123e);
    wreg(`PFC_OFF_WORD0, 32'hcafe_0005);
    rchk(`PFC_OFF_TAG, 32'h8000_123e);
    rchk(`PFC_OFF_WORD0, 32'hcafe_0005);
    @(posedge clk) prot <= 1'b1;
    rchk(`PFC_OFF_WORD0, 32'h0);
    @(posedge clk) prot <= 1'b0;
    look(32'h1d00_1230, 1'b1, 1'b1, 4'h5);
    chk(last_word, 32'hcafe_0005);
    look(32'h1f00_1230, 1'b1, 1'b0, 4'h0);
    look(32'h1d00_1230, 1'b0, 1'b0, 4'h0);
    // Mask only on lines 0x0a and 0x0b
    line(4'h3, 32'h0);
    wreg(`PFC_OFF_MASK, 32'h20);
    rchk(`PFC_OFF_MASK, 32'h0);
    line(4'ha, 32'h8000_456a);
    wreg(`PFC_OFF_MASK, 32'h20);
    rchk(`PFC_OFF_MASK, 32'h20);
    look(32'h1d00_4540, 1'b1, 1'b1, 4'ha);
    // Program cycle, coherency off: locked data line still goes
    line(4'h1, 32'h8000_789c);
    wreg(`PFC_OFF_CONTROL, 32'h300);
    pulse();
    look(32'h1d00_4560, 1'b1, 1'b0, 4'h0);
    look(32'h1d00_1230, 1'b1, 1'b1, 4'h5);
    rchk(`PFC_OFF_TAG, 32'h8000_789c & ~32'h8);
    wreg(`PFC_OFF_ACCESS, 32'ha);
    rchk(`PFC_OFF_TAG, 32'h8000_4562);
    // Coherency on: locked instruction line goes too
    wreg(`PFC_OFF_CONTROL, 32'h1_0300);
    pulse();
    wreg(`PFC_OFF_ACCESS, 32'h5);
    rchk(`PFC_OFF_TAG, 32'h8000_1236);
    // Size change invalidates every line
    wreg(`PFC_OFF_TAG, 32'h8000_123e);
    wreg(`PFC_OFF_CONTROL, 32'h1_0000);
    // Flush clears the lines two cycles after the write is taken
    @(posedge clk);
    rchk(`PFC_OFF_TAG, 32'h8000_1236);
    look(32'h1d00_1230, 1'b1, 1'b0, 4'h0);
    // Only line 15 unlocked: the fill must land there
    for (int i = 0; i < 15; i++) begin
      line(i[3:0], 32'h6);
    end
    line(4'hf, 32'h2);
    i_pfc_core_model.fill(32'h1d00_abc0, 32'h1234_5678, 1'b1);
    look(32'h1d00_abc0, 1'b1, 1'b1, 4'hf);
    chk(last_word, 32'h1234_5678);
    wreg(`PFC_OFF_ACCESS, 32'h4);
    rchk(`PFC_OFF_TAG, 32'h6);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
